// ==== logic/cgr_pkg.sv ====
package cgr_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_SYS_ENABLE = 8'h00;
	localparam logic [7:0] OFS_SYS_DISABLE = 8'h04;
	localparam logic [7:0] OFS_SYS_STATE = 8'h08;
	localparam logic [7:0] OFS_PER_ENABLE = 8'h10;
	localparam logic [7:0] OFS_PER_DISABLE = 8'h14;
	localparam logic [7:0] OFS_PER_STATE = 8'h18;
	localparam logic [7:0] OFS_OSC_CTRL = 8'h20;
	localparam logic [7:0] OFS_FREQ_MEAS = 8'h24;
	localparam logic [7:0] OFS_PLL_CFG = 8'h2C;
	localparam logic [7:0] OFS_LOCK_STATE = 8'h68;
	// System clock bit positions
	localparam int POS_PROC = 0;
	localparam int POS_USB = 7;
	localparam int POS_PROG0 = 8;
	localparam int NUM_PROG = 3;
	localparam logic [31:0] SYS_MASK = 32'h0000_0781;
	localparam logic [31:0] PER_MASK = 32'hFFFF_FFFC;
	// Reset values
	localparam logic [31:0] RST_SYS = 32'h0000_0001;
	localparam logic [31:0] RST_PER = 32'h0000_0000;
	localparam logic [15:0] RST_OSC = 16'h0000;
	localparam logic [31:0] RST_PLL = 32'h0000_3F00;
	// Oscillator control fields
	localparam int POS_OSC_ON = 0;
	localparam int POS_BYPASS = 1;
	localparam int POS_STARTUP = 8;
	localparam int POS_FREQ_VALID = 16;
	// PLL fields
	localparam int POS_DIV = 0;
	localparam int POS_LOCKW = 8;
	localparam int POS_RANGE = 14;
	localparam int POS_GAIN = 16;
	localparam int POS_USBR = 28;
	localparam logic [31:0] PLL_MASK = 32'h37FF_FFFF;
	// Status register bit positions
	localparam int POS_ST_STABLE = 0;
	localparam int POS_ST_LOCK = 2;
	// Timing counts in slow clock cycles
	localparam int STARTUP_UNIT = 8;
	localparam int MEAS_PERIODS = 16;
	// Slow clock rate and the core rate that the slow tick is derived from
	localparam int CORE_HZ = 10_000_000;
	localparam int SLOW_HZ = 32_768;
	localparam int SLOW_DIV = CORE_HZ / SLOW_HZ;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} cgr_req_t;

	typedef struct packed {
		logic [1:0] usb_ratio;
		logic [10:0] gain;
		logic [1:0] range;
		logic [5:0] lock_wait;
		logic [7:0] div;
	} cgr_pll_t;
endpackage

// ==== logic/cgr_top.sv ====
`timescale 1ns/1ps
module cgr_top #(
	parameter int NUM_PER = 30,
	parameter int SLOW_DIV = cgr_pkg::SLOW_DIV
) (
	// Clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RESETN,
	// Register port
	input wire logic [7:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [31:0] O_RDATA,
	// Main clock edge marker from the oscillator pad
	input wire logic I_MAIN_CLK_MARK,
	// Clock gates
	output logic O_PROC_CLK_ON,
	output logic O_PROC_IDLE,
	output logic O_USB_PORT_CLOCK_ON,
	output logic [2:0] O_PROG_OUT_ON,
	output logic [31:0] O_PER_CLK_ON,
	// Oscillator and PLL controls
	output logic O_OSC_ON,
	output logic O_OSC_BYPASS,
	output logic O_MAIN_STABLE,
	output logic O_PLL_ACTIVE,
	output logic O_PLL_LOCKED,
	output logic [7:0] O_PLL_DIV,
	output logic O_PLL_DIV_OFF,
	output logic O_PLL_DIV_BYPASS,
	output logic [11:0] O_PLL_FACTOR,
	output logic [2:0] O_USB_DIVIDE
);
	typedef enum logic [2:0] {
		M_IDLE = 3'h1,
		M_RUN = 3'h2,
		M_DONE = 3'h4
	} cgr_meas_t;

	cgr_pkg::cgr_req_t req;
	assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	wire wr_sys_en = req.wr && hit(req.addr, cgr_pkg::OFS_SYS_ENABLE);
	wire wr_sys_dis = req.wr && hit(req.addr, cgr_pkg::OFS_SYS_DISABLE);
	wire wr_per_en = req.wr && hit(req.addr, cgr_pkg::OFS_PER_ENABLE);
	wire wr_per_dis = req.wr && hit(req.addr, cgr_pkg::OFS_PER_DISABLE);
	wire wr_osc = req.wr && hit(req.addr, cgr_pkg::OFS_OSC_CTRL);
	wire wr_pll = req.wr && hit(req.addr, cgr_pkg::OFS_PLL_CFG);

	// Only implemented peripheral identifiers may toggle
	localparam logic [31:0] PER_IMPL = cgr_pkg::PER_MASK &
		(32'hFFFF_FFFF >> (30 - NUM_PER));

	logic [31:0] sys_q, sys_d;
	logic [31:0] per_q, per_d;
	logic [15:0] osc_q;
	logic [31:0] pll_q;
	logic stable_q, stable_d;
	logic lock_q;
	logic [10:0] start_cnt_q;
	logic [5:0] lock_cnt_q;
	logic [15:0] slow_cnt_q;
	logic slow_tick;
	logic mark_s1_q, mark_s2_q, mark_s3_q;
	logic [15:0] main_cnt_q, freq_q;
	logic [4:0] per_cnt_q;
	logic valid_q;
	cgr_meas_t meas_q;

	assign sys_d = (sys_q | (wr_sys_en ? (req.wdata & cgr_pkg::SYS_MASK) : '0))
		& ~(wr_sys_dis ? (req.wdata & cgr_pkg::SYS_MASK) : '0);
	assign per_d = (per_q | (wr_per_en ? (req.wdata & PER_IMPL) : '0))
		& ~(wr_per_dis ? (req.wdata & PER_IMPL) : '0);

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			sys_q <= cgr_pkg::RST_SYS;
			per_q <= cgr_pkg::RST_PER;
		end
		else
		begin
			sys_q <= sys_d;
			per_q <= per_d;
		end
	end

	// Slow clock tick derived from the core clock
	assign slow_tick = slow_cnt_q == 16'(SLOW_DIV - 1);
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
			slow_cnt_q <= '0;
		else
			slow_cnt_q <= slow_tick ? '0 : slow_cnt_q + 16'h0001;
	end

	// Oscillator control and start-up counter
	wire osc_on = osc_q[cgr_pkg::POS_OSC_ON];
	wire osc_byp = osc_q[cgr_pkg::POS_BYPASS];
	wire osc_rise = wr_osc && req.wdata[cgr_pkg::POS_OSC_ON] && !osc_on;
	wire start_done = start_cnt_q == 11'h000;

	always_comb
	begin
		stable_d = stable_q;
		if (osc_byp)
			stable_d = 1'b1;
		else if (!osc_on)
			stable_d = 1'b0;
		else if (slow_tick && start_cnt_q <= 11'h001)
			stable_d = 1'b1;
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			osc_q <= cgr_pkg::RST_OSC;
			start_cnt_q <= '0;
			stable_q <= 1'b0;
		end
		else
		begin
			if (wr_osc)
				osc_q <= {req.wdata[15:8], 6'h00, req.wdata[1:0]};
			if (osc_rise)
				start_cnt_q <= {req.wdata[cgr_pkg::POS_STARTUP +: 8], 3'h0};
			else if (slow_tick && !start_done)
				start_cnt_q <= start_cnt_q - 11'h001;
			stable_q <= osc_rise ? 1'b0 : stable_d;
		end
	end

	// Frequency measurement; the mark input crosses domains first
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			mark_s1_q <= 1'b0;
			mark_s2_q <= 1'b0;
			mark_s3_q <= 1'b0;
		end
		else
		begin
			mark_s1_q <= I_MAIN_CLK_MARK;
			mark_s2_q <= mark_s1_q;
			mark_s3_q <= mark_s2_q;
		end
	end
	wire main_edge = mark_s2_q && !mark_s3_q;

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			meas_q <= M_IDLE;
			main_cnt_q <= '0;
			freq_q <= '0;
			per_cnt_q <= '0;
			valid_q <= 1'b0;
		end
		else if (!osc_on && !osc_byp)
		begin
			meas_q <= M_IDLE;
			valid_q <= 1'b0;
		end
		else
		begin
			unique case (meas_q)
				M_IDLE:
					if (stable_q && slow_tick)
					begin
						meas_q <= M_RUN;
						main_cnt_q <= '0;
						per_cnt_q <= '0;
					end
				M_RUN:
				begin
					if (main_edge)
						main_cnt_q <= main_cnt_q + 16'h0001;
					if (slow_tick)
					begin
						per_cnt_q <= per_cnt_q + 5'h01;
						if (per_cnt_q == 5'(cgr_pkg::MEAS_PERIODS - 1))
						begin
							meas_q <= M_DONE;
							// Edge on the closing tick counts, so the window is sixteen periods
							freq_q <= main_cnt_q + (main_edge ? 16'h0001 : 16'h0000);
							valid_q <= 1'b1;
						end
					end
				end
				M_DONE:
					meas_q <= M_DONE;
			endcase
		end
	end

	// PLL configuration and lock wait
	cgr_pkg::cgr_pll_t pll;
	assign pll = {pll_q[29:28], pll_q[26:16], pll_q[15:14], pll_q[13:8], pll_q[7:0]};

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			pll_q <= cgr_pkg::RST_PLL;
			lock_cnt_q <= '0;
			lock_q <= 1'b0;
		end
		else if (wr_pll)
		begin
			pll_q <= req.wdata & cgr_pkg::PLL_MASK;
			lock_cnt_q <= req.wdata[13:8];
			lock_q <= 1'b0;
		end
		else if (slow_tick)
		begin
			if (lock_cnt_q != 6'h00)
				lock_cnt_q <= lock_cnt_q - 6'h01;
			// The tick that ends the wait grants lock, not the one after it
			if (lock_cnt_q <= 6'h01)
				lock_q <= pll.gain != 11'h000;
		end
	end

	// Read mux
	logic [31:0] rmux;
	always_comb
	begin
		unique case (req.addr)
			cgr_pkg::OFS_SYS_STATE: rmux = sys_q;
			cgr_pkg::OFS_PER_STATE: rmux = per_q;
			cgr_pkg::OFS_OSC_CTRL: rmux = {16'h0000, osc_q};
			cgr_pkg::OFS_FREQ_MEAS: rmux = {15'h0000, valid_q, freq_q};
			cgr_pkg::OFS_PLL_CFG: rmux = pll_q;
			cgr_pkg::OFS_LOCK_STATE: rmux = {29'h0, lock_q, 1'b0, stable_q};
			default: rmux = '0;
		endcase
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			O_RDATA <= '0;
			O_PROC_CLK_ON <= 1'b1;
			O_PROC_IDLE <= 1'b0;
			O_USB_PORT_CLOCK_ON <= 1'b0;
			O_PROG_OUT_ON <= '0;
			O_PER_CLK_ON <= '0;
			O_OSC_ON <= 1'b0;
			O_OSC_BYPASS <= 1'b0;
			O_MAIN_STABLE <= 1'b0;
			O_PLL_ACTIVE <= 1'b0;
			O_PLL_LOCKED <= 1'b0;
			O_PLL_DIV <= '0;
			O_PLL_DIV_OFF <= 1'b0;
			O_PLL_DIV_BYPASS <= 1'b0;
			O_PLL_FACTOR <= '0;
			O_USB_DIVIDE <= 3'h1;
		end
		else
		begin
			O_RDATA <= req.rd ? rmux : '0;
			O_PROC_CLK_ON <= sys_d[cgr_pkg::POS_PROC];
			O_PROC_IDLE <= !sys_d[cgr_pkg::POS_PROC];
			O_USB_PORT_CLOCK_ON <= sys_d[cgr_pkg::POS_USB];
			O_PROG_OUT_ON <= sys_d[cgr_pkg::POS_PROG0 +: cgr_pkg::NUM_PROG];
			O_PER_CLK_ON <= per_d;
			O_OSC_ON <= osc_on;
			O_OSC_BYPASS <= osc_byp;
			O_MAIN_STABLE <= stable_q;
			O_PLL_ACTIVE <= pll.gain != 11'h000;
			O_PLL_LOCKED <= lock_q;
			O_PLL_DIV <= pll.div;
			O_PLL_DIV_OFF <= pll.div == 8'h00;
			O_PLL_DIV_BYPASS <= pll.div == 8'h01;
			O_PLL_FACTOR <= {1'b0, pll.gain} + 12'h001;
			unique case (pll.usb_ratio)
				2'b00: O_USB_DIVIDE <= 3'h1;
				2'b01: O_USB_DIVIDE <= 3'h2;
				2'b10: O_USB_DIVIDE <= 3'h4;
				default: O_USB_DIVIDE <= 3'h0;
			endcase
		end
	end

	a_sys_enable_set: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
		wr_sys_en && req.wdata[0] && !wr_sys_dis |=> sys_q[0])
		else $error("processor clock not enabled");
	a_sys_disable_clr: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
		wr_sys_dis && req.wdata[7] |=> !sys_q[7] && !O_USB_PORT_CLOCK_ON)
		else $error("usb clock not disabled");
	a_idle_follows: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
		O_PROC_IDLE == !O_PROC_CLK_ON)
		else $error("idle mismatch");
	a_per_low_bits: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
		per_q[1:0] == 2'b00)
		else $error("peripheral bits 0-1 set");
	a_bypass_stable: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
		osc_byp && !osc_on && !wr_osc |=> stable_q)
		else $error("bypass not stable");
	a_osc_off_clear: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
		!osc_on && !osc_byp |=> !stable_q && !valid_q)
		else $error("stable not cleared");
	a_pll_write_unlock: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
		wr_pll |=> !lock_q ##1 !O_PLL_LOCKED)
		else $error("lock during wait");
	a_pll_readback: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
		wr_pll |=> pll_q == ($past(req.wdata) & cgr_pkg::PLL_MASK))
		else $error("pll readback wrong");
	a_sys_state_read: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
		req.rd && req.addr == cgr_pkg::OFS_SYS_STATE |=> O_RDATA == $past(sys_q))
		else $error("system state read wrong");
	a_sys_ones_set: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
		wr_sys_en |=> (sys_q & $past(req.wdata) & cgr_pkg::SYS_MASK) ==
			($past(req.wdata) & cgr_pkg::SYS_MASK))
		else $error("system enable not applied");
	a_per_ones_set: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
		wr_per_en |=> (per_q & $past(req.wdata) & PER_IMPL) == ($past(req.wdata) & PER_IMPL))
		else $error("peripheral enable not applied");
	a_per_ones_clr: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
		wr_per_dis |=> (per_q & $past(req.wdata) & PER_IMPL) == 32'h0000_0000)
		else $error("peripheral disable not applied");
	a_per_unimpl: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
		(per_q & ~PER_IMPL) == 32'h0000_0000)
		else $error("unimplemented peripheral bit set");
	a_start_wait: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
		osc_on && !osc_byp && !stable_q && start_cnt_q > 11'h001 |=> !stable_q)
		else $error("stable before start-up delay");
	a_valid_after_meas: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
		valid_q |-> meas_q == M_DONE)
		else $error("valid without measurement");
	a_lock_wait: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
		lock_cnt_q > 6'h01 && !lock_q |=> !lock_q)
		else $error("lock before wait ends");
	a_lock_needs_gain: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
		lock_q |-> pll.gain != 11'h000)
		else $error("lock with pll off");
	a_usb_ratio_four: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
		wr_pll && req.wdata[29:28] == 2'b10 ##1 !wr_pll |=> O_USB_DIVIDE == 3'h4)
		else $error("usb ratio wrong");
endmodule // cgr_top

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
	logic I_CORE_CLK = 1'b0;
	logic I_RESETN = 1'b0;
	logic [7:0] I_ADDR = 8'h00;
	logic [31:0] I_WDATA = 32'h0;
	logic I_WR = 1'b0;
	logic I_RD = 1'b0;
	logic I_MAIN_CLK_MARK = 1'b0;
	logic [31:0] O_RDATA, O_PER_CLK_ON;
	logic O_PROC_CLK_ON, O_PROC_IDLE, O_USB_PORT_CLOCK_ON, O_OSC_ON, O_OSC_BYPASS;
	logic O_MAIN_STABLE, O_PLL_ACTIVE, O_PLL_LOCKED, O_PLL_DIV_OFF, O_PLL_DIV_BYPASS;
	logic [2:0] O_PROG_OUT_ON, O_USB_DIVIDE;
	logic [7:0] O_PLL_DIV;
	logic [11:0] O_PLL_FACTOR;
	logic [63:0] exp_q[$];
	logic [63:0] note;
	logic rd_pend = 1'b0;
	logic [1:0] mark_cnt = 2'h0;
	logic [31:0] sys_m, per_m, d, pll_w;
	logic [10:0] gains[4] = '{11'h000, 11'h005, 11'h7FF, 11'h001};
	logic [7:0] divs[4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
	logic [2:0] usbd[4] = '{3'h1, 3'h2, 3'h4, 3'h0};
	int bad_count = 0;
	int num_checks = 0;
	int seed = 32'h85FA6C0D;
	int n;
	int k;

	// Slow tick divider shortened so start-up and lock waits stay brief
	cgr_top #(.NUM_PER(30), .SLOW_DIV(4)) cgr_top_i (
		.I_CORE_CLK(I_CORE_CLK), .I_RESETN(I_RESETN), .I_ADDR(I_ADDR),
		.I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
		.I_MAIN_CLK_MARK(I_MAIN_CLK_MARK), .O_PROC_CLK_ON(O_PROC_CLK_ON),
		.O_PROC_IDLE(O_PROC_IDLE), .O_USB_PORT_CLOCK_ON(O_USB_PORT_CLOCK_ON),
		.O_PROG_OUT_ON(O_PROG_OUT_ON), .O_PER_CLK_ON(O_PER_CLK_ON), .O_OSC_ON(O_OSC_ON),
		.O_OSC_BYPASS(O_OSC_BYPASS), .O_MAIN_STABLE(O_MAIN_STABLE),
		.O_PLL_ACTIVE(O_PLL_ACTIVE), .O_PLL_LOCKED(O_PLL_LOCKED), .O_PLL_DIV(O_PLL_DIV),
		.O_PLL_DIV_OFF(O_PLL_DIV_OFF), .O_PLL_DIV_BYPASS(O_PLL_DIV_BYPASS),
		.O_PLL_FACTOR(O_PLL_FACTOR), .O_USB_DIVIDE(O_USB_DIVIDE)
	);

	always #50 I_CORE_CLK = ~I_CORE_CLK;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Mark period equals the slow tick, so any 16-tick window holds 16 edges
	always @(posedge I_CORE_CLK)
	begin
		mark_cnt <= mark_cnt + 2'h1;
		I_MAIN_CLK_MARK <= mark_cnt[1];
		rd_pend <= I_RD;
		if (rd_pend)
		begin
			note = exp_q.pop_front();
			check(O_RDATA & note[63:32], note[31:0]);
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge I_CORE_CLK);
		I_ADDR <= a;
		I_WDATA <= v;
		I_WR <= 1'b1;
		I_RD <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hFFFF_FFFF);
		@(posedge I_CORE_CLK);
		I_ADDR <= a;
		I_WR <= 1'b0;
		I_RD <= 1'b1;
		exp_q.push_back({m, e & m});
	endtask

	task automatic idle(input int c);
		@(posedge I_CORE_CLK);
		I_WR <= 1'b0;
		I_RD <= 1'b0;
		repeat (c) @(posedge I_CORE_CLK);
		#1;
	endtask

	initial
	begin
		repeat (5000) @(posedge I_CORE_CLK);
		bad_count++;
		final_report;
	end

	initial
	begin
		repeat (8) @(posedge I_CORE_CLK);
		I_RESETN <= 1'b1;
		rd(cgr_pkg::OFS_SYS_STATE, cgr_pkg::RST_SYS);
		rd(cgr_pkg::OFS_PER_STATE, cgr_pkg::RST_PER);
		rd(cgr_pkg::OFS_FREQ_MEAS, 32'h0);
		rd(cgr_pkg::OFS_PLL_CFG, cgr_pkg::RST_PLL);
		rd(8'h0C, 32'h0);
		idle(2);
		$display("reset values done");
		sys_m = cgr_pkg::RST_SYS;
		per_m = cgr_pkg::RST_PER;
		for (n = 0; n < 8; n++)
		begin
			d = $random(seed);
			wr(cgr_pkg::OFS_SYS_ENABLE, d);
			sys_m = sys_m | (d & cgr_pkg::SYS_MASK);
			rd(cgr_pkg::OFS_SYS_STATE, sys_m);
			d = $random(seed);
			wr(cgr_pkg::OFS_SYS_DISABLE, d);
			sys_m = sys_m & ~(d & cgr_pkg::SYS_MASK);
			rd(cgr_pkg::OFS_SYS_STATE, sys_m);
			d = $random(seed);
			wr(cgr_pkg::OFS_PER_ENABLE, d);
			per_m = per_m | (d & cgr_pkg::PER_MASK);
			wr(8'h0C, $random(seed));
			rd(cgr_pkg::OFS_PER_STATE, per_m);
			d = $random(seed);
			wr(cgr_pkg::OFS_PER_DISABLE, d);
			per_m = per_m & ~(d & cgr_pkg::PER_MASK);
			rd(cgr_pkg::OFS_PER_STATE, per_m);
			idle(2);
			check(O_PROC_CLK_ON, sys_m[0]);
			check(O_PROC_IDLE, !sys_m[0]);
			check(O_USB_PORT_CLOCK_ON, sys_m[7]);
			check(O_PROG_OUT_ON, sys_m[10:8]);
			check(O_PER_CLK_ON, per_m);
		end
		$display("clock gates done");
		wr(cgr_pkg::OFS_OSC_CTRL, 32'h0000_0201);
		rd(cgr_pkg::OFS_OSC_CTRL, 32'h0000_0201);
		rd(cgr_pkg::OFS_LOCK_STATE, 32'h0, 32'h1);
		idle(50);
		check(O_MAIN_STABLE, 1'b0);
		k = 0;
		while (O_MAIN_STABLE !== 1'b1 && k < 40)
		begin
			@(posedge I_CORE_CLK);
			#1;
			k++;
		end
		check(k inside {[9:14]}, 1'b1);
		idle(90);
		rd(cgr_pkg::OFS_FREQ_MEAS, 32'h0001_0010);
		wr(cgr_pkg::OFS_OSC_CTRL, 32'h0);
		idle(2);
		check(O_MAIN_STABLE, 1'b0);
		rd(cgr_pkg::OFS_FREQ_MEAS, 32'h0, 32'h0001_0000);
		wr(cgr_pkg::OFS_OSC_CTRL, 32'h0000_0002);
		idle(2);
		check({O_MAIN_STABLE, O_OSC_BYPASS, O_OSC_ON}, 3'h6);
		$display("oscillator done");
		for (n = 0; n < 4; n++)
		begin
			pll_w = {2'b00, n[1:0], 1'b0, gains[n], 2'b01, 6'h03, divs[n]};
			wr(cgr_pkg::OFS_PLL_CFG, pll_w | 32'hC800_0000);
			rd(cgr_pkg::OFS_PLL_CFG, pll_w);
			rd(cgr_pkg::OFS_LOCK_STATE, 32'h1, 32'h5);
			idle(30);
			check(O_PLL_LOCKED, gains[n] != 11'h0);
			check(O_PLL_ACTIVE, gains[n] != 11'h0);
			check(O_PLL_FACTOR, {1'b0, gains[n]} + 12'h001);
			check(O_USB_DIVIDE, usbd[n]);
			check(O_PLL_DIV, divs[n]);
			check({O_PLL_DIV_OFF, O_PLL_DIV_BYPASS}, {divs[n] == 8'h0, divs[n] == 8'h1});
		end
		$display("pll done");
		idle(4);
		final_report;
	end
endmodule // tb
